/* File: design/can_ctl_pkg.sv */
package can_ctl_pkg;
	localparam int OBJ_N = 15;
	localparam int OBJ_AW = 4;
	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_GCTRL = 8'h00;
	localparam logic [7:0] OFS_BTIME = 8'h04;
	localparam logic [7:0] OFS_IRQEN = 8'h08;
	localparam logic [7:0] OFS_OBJEN = 8'h0C;
	localparam logic [7:0] OFS_OBJIRQ = 8'h10;
	localparam logic [7:0] OFS_GIRQ = 8'h14;
	localparam logic [7:0] OFS_TIMER = 8'h18;
	localparam logic [7:0] OFS_TTCAP = 8'h1C;
	localparam logic [7:0] OFS_ERRCNT = 8'h20;
	localparam logic [7:0] OFS_OBJSEL = 8'h24;
	localparam logic [7:0] OFS_OBJSTAT = 8'h28;
	localparam logic [7:0] OFS_STAMP = 8'h2C;
	localparam logic [7:0] OFS_TAGID = 8'h30;
	localparam logic [7:0] OFS_TAGFL = 8'h34;
	localparam logic [7:0] OFS_MSKID = 8'h38;
	localparam logic [7:0] OFS_MSKFL = 8'h3C;
	localparam logic [7:0] OFS_BUFGRP = 8'h40;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int GC_ENA = 1;
	localparam int GC_LISTEN = 3;
	localparam int GC_SYNCSEL = 4;
	localparam int GC_TT = 5;
	localparam int BT_PRESC = 0;
	localparam int BT_PROP = 8;
	localparam int BT_PH1 = 12;
	localparam int BT_PH2 = 16;
	localparam int BT_SJW = 20;
	localparam int IE_GLOBAL = 0;
	localparam int IE_GENERR = 1;
	localparam int IE_BUF = 2;
	localparam int IE_TIMER = 3;
	localparam int IE_OBJERR = 4;
	localparam int IE_RX = 5;
	localparam int IE_TX = 6;
	localparam int GI_BIT = 0;
	localparam int GI_FORM = 3;
	localparam int GI_TOV = 5;
	localparam int GI_BOV = 6;
	localparam int OS_RXOK = 0;
	localparam int OS_TRANSMIT_OK_FLAG = 1;
	localparam int OS_ERR = 2;
	localparam int EC_REC = 16;
	localparam int EC_STATE = 24;
	// ----------------------------------------
	// Reset values and counts
	// ----------------------------------------
	localparam logic [5:0] PRESC_RST = 6'h00;
	localparam logic [2:0] SEG_RST = 3'h0;
	localparam logic [1:0] SJW_RST = 2'h0;
	localparam logic [6:0] IRQEN_RST = 7'h00;
	localparam logic [9:0] TEC_INC = 10'h008;
	localparam logic [8:0] TEC_OFF = 9'h100;
	localparam logic [7:0] REC_MAX = 8'hFF;
	localparam logic [3:0] SUSPEND_BITS = 4'h8;
	localparam logic [15:0] TIMER_MAX = 16'hFFFF;
	localparam logic [OBJ_N-1:0] ONE_OBJ = 15'h0001;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {SEG_SYNC, SEG_PROP, SEG_PH1, SEG_PH2} seg_type;
	typedef enum logic [1:0] {FC_ACTIVE, FC_PASSIVE, FC_BUSOFF} fault_type;
	// Tag layout: {ide, reserved[1:0], remote, identifier[28:0]}
	typedef struct packed {
		logic [15:0] stamp;
		logic [32:0] mask;
		logic [32:0] tag;
	} obj_entry_type;
	typedef struct packed {
		logic sof;
		logic eof;
		logic rx_done;
		logic tx_ok;
		logic [OBJ_AW-1:0] obj;
		logic [28:0] identifier_tag;
		logic remote_request_tag;
		logic [1:0] reserved_bits_tag;
		logic ide;
		logic err_valid;
		logic [4:0] err_kind;
		logic err_in_tx;
		logic err_obj_valid;
	} frame_event_type;
	typedef struct packed {
		logic drive_allowed;
		logic tx_allowed;
		logic ack_allowed;
		logic active_error_frame;
		logic retransmit_allowed;
		logic sample_point;
		logic bit_start;
		logic rx_bit;
	} node_ctrl_type;
endpackage : can_ctl_pkg

/* File: design/obj_store.sv */
`timescale 1ns/1ps
module obj_store #(
	parameter int W = 82,
	parameter int D = 15,
	parameter int AW = 4
) (
	input wire logic clk,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [W-1:0] wmask,
	input wire logic [W-1:0] wdata,
	input wire logic [AW-1:0] raddr_a,
	output logic [W-1:0] rdata_a,
	input wire logic [AW-1:0] raddr_b,
	output logic [W-1:0] rdata_b
);
	logic [W-1:0] mem [D];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= (mem[waddr] & ~wmask) | (wdata & wmask);
		end
	end

	always_ff @(posedge clk) begin
		rdata_a <= mem[raddr_a];
		rdata_b <= mem[raddr_b];
	end
endmodule : obj_store

/* File: design/can_ctl.sv */
// What this block does
// - Object error irq needs global, object, error enables
// - Buffer irq gated globally; timer irq own enable
// - Raising object sets its status irq bit
// - Own form error while sending also flags bit
// - Object errors never set general error flags
// - Quantum is prescaler plus one clocks; sync 1
// - Propagation segment lasts field plus one quanta
// - Phase one lasts field plus one quanta
// - Jump width is min(field+1, phase one)
// - Error active node joins, sends active error frames
// - Passive node sends passive frames, suspends transmit
// - Bus-off never drives; counters drive confinement
// - Acceptance hit writes received fields into tag
// - Timer runs once enabled, wraps to zero
// - Trigger mode captures timer at chosen frame edge
// - Trigger mode sends each frame only once
// - Stamp taken when receive ok sets, or transmit ok without a same-cycle receive hit
// - Timer rollover requests irq when enabled
// - Listen mode: no ack, no send, counters frozen
// - Full receive buffer group sets overrun flag
`timescale 1ns/1ps
module can_ctl (
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic [7:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	input wire logic RX_PIN,
	input wire can_ctl_pkg::frame_event_type EVT,
	output can_ctl_pkg::node_ctrl_type CTRL,
	output logic IRQ
);
	import can_ctl_pkg::*;

	logic ena_reg, listen_reg, sync_sel_reg, tt_reg;
	logic [5:0] presc_reg;
	logic [2:0] prop_reg, ph1_reg, ph2_reg;
	logic [1:0] sjw_reg;
	logic [6:0] ie_reg;
	logic [OBJ_N-1:0] obj_en_reg, bufgrp_reg, rxok_reg, transmit_ok_flag_reg, oerr_reg;
	logic [OBJ_AW-1:0] objsel_reg, objsel_next;
	logic [4:0] gen_err_reg;
	logic tov_reg, bov_reg, full_d_reg;
	logic [15:0] timer_reg, ttcap_reg;
	logic [8:0] tec_reg;
	logic [7:0] rec_reg;
	logic [3:0] susp_reg;
	fault_type fault;
	logic req, ack_reg, done, wr, mem_field, hw_we, bus_we;
	logic [31:0] rdata_next;
	logic [OBJ_N-1:0] sel_vec, obj_irq_vec, clr_vec;
	obj_entry_type rd_a, rd_b, wmask, wdata;
	logic rx_chk_reg, rx_match, full_now, timer_wrap;
	logic [OBJ_AW-1:0] rx_obj_reg, waddr;
	logic [32:0] rx_tag_reg;

	// ----------------------------------------
	// Avalon slave
	// ----------------------------------------
	assign req = AVS_READ | AVS_WRITE;
	assign mem_field = AVS_ADDRESS inside {OFS_TAGID, OFS_TAGFL, OFS_MSKID, OFS_MSKFL};
	// A tag or mask write waits while hardware owns the object store
	assign AVS_WAITREQUEST = req & (~ack_reg | (AVS_WRITE & mem_field & hw_we));
	assign done = req & ~AVS_WAITREQUEST;
	assign wr = AVS_WRITE & done;

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= req & ~done;
		end
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			AVS_READDATA <= 32'h00000000;
		end else if (req & ~ack_reg) begin
			AVS_READDATA <= rdata_next;
		end
	end

	always_comb begin
		rdata_next = 32'h00000000;
		case (AVS_ADDRESS)
			OFS_GCTRL: begin
				rdata_next[GC_ENA] = ena_reg;
				rdata_next[GC_LISTEN] = listen_reg;
				rdata_next[GC_SYNCSEL] = sync_sel_reg;
				rdata_next[GC_TT] = tt_reg;
			end
			OFS_BTIME: begin
				rdata_next[BT_PRESC +: 6] = presc_reg;
				rdata_next[BT_PROP +: 3] = prop_reg;
				rdata_next[BT_PH1 +: 3] = ph1_reg;
				rdata_next[BT_PH2 +: 3] = ph2_reg;
				rdata_next[BT_SJW +: 2] = sjw_reg;
			end
			OFS_IRQEN: rdata_next[6:0] = ie_reg;
			OFS_OBJEN: rdata_next[OBJ_N-1:0] = obj_en_reg;
			OFS_OBJIRQ: rdata_next[OBJ_N-1:0] = obj_irq_vec;
			OFS_GIRQ: rdata_next[GI_BOV:0] = {bov_reg, tov_reg, gen_err_reg};
			OFS_TIMER: rdata_next[15:0] = timer_reg;
			OFS_TTCAP: rdata_next[15:0] = ttcap_reg;
			OFS_ERRCNT: begin
				rdata_next[8:0] = tec_reg;
				rdata_next[EC_REC +: 8] = rec_reg;
				rdata_next[EC_STATE +: 2] = fault;
			end
			OFS_OBJSEL: rdata_next[OBJ_AW-1:0] = objsel_reg;
			OFS_OBJSTAT: begin
				rdata_next[OS_RXOK] = |(rxok_reg & sel_vec);
				rdata_next[OS_TRANSMIT_OK_FLAG] = |(transmit_ok_flag_reg & sel_vec);
				rdata_next[OS_ERR] = |(oerr_reg & sel_vec);
			end
			OFS_STAMP: rdata_next[15:0] = rd_a.stamp;
			OFS_TAGID: rdata_next[28:0] = rd_a.tag[28:0];
			OFS_TAGFL: rdata_next[3:0] = rd_a.tag[32:29];
			OFS_MSKID: rdata_next[28:0] = rd_a.mask[28:0];
			OFS_MSKFL: rdata_next[3:0] = rd_a.mask[32:29];
			OFS_BUFGRP: rdata_next[OBJ_N-1:0] = bufgrp_reg;
			default: rdata_next = 32'h00000000;
		endcase
	end

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			ena_reg <= 1'b0;
			listen_reg <= 1'b0;
			sync_sel_reg <= 1'b0;
			tt_reg <= 1'b0;
			presc_reg <= PRESC_RST;
			prop_reg <= SEG_RST;
			ph1_reg <= SEG_RST;
			ph2_reg <= SEG_RST;
			sjw_reg <= SJW_RST;
			ie_reg <= IRQEN_RST;
			obj_en_reg <= '0;
			bufgrp_reg <= '0;
		end else if (wr) begin
			case (AVS_ADDRESS)
				OFS_GCTRL: begin
					ena_reg <= AVS_WRITEDATA[GC_ENA];
					listen_reg <= AVS_WRITEDATA[GC_LISTEN];
					sync_sel_reg <= AVS_WRITEDATA[GC_SYNCSEL];
					tt_reg <= AVS_WRITEDATA[GC_TT];
				end
				OFS_BTIME: begin
					presc_reg <= AVS_WRITEDATA[BT_PRESC +: 6];
					prop_reg <= AVS_WRITEDATA[BT_PROP +: 3];
					ph1_reg <= AVS_WRITEDATA[BT_PH1 +: 3];
					ph2_reg <= AVS_WRITEDATA[BT_PH2 +: 3];
					sjw_reg <= AVS_WRITEDATA[BT_SJW +: 2];
				end
				OFS_IRQEN: ie_reg <= AVS_WRITEDATA[6:0];
				OFS_OBJEN: obj_en_reg <= AVS_WRITEDATA[OBJ_N-1:0];
				OFS_BUFGRP: bufgrp_reg <= AVS_WRITEDATA[OBJ_N-1:0];
				default: ;
			endcase
		end
	end

	always_comb begin
		objsel_next = objsel_reg;
		if (wr && AVS_ADDRESS == OFS_OBJSEL && AVS_WRITEDATA[OBJ_AW-1:0] < OBJ_AW'(OBJ_N)) begin
			objsel_next = AVS_WRITEDATA[OBJ_AW-1:0];
		end
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			objsel_reg <= '0;
		end else begin
			objsel_reg <= objsel_next;
		end
	end

	assign sel_vec = ONE_OBJ << objsel_reg;

	// ----------------------------------------
	// Object store: stamp, mask, tag
	// ----------------------------------------
	assign rx_match = rx_chk_reg & (((rd_b.tag ^ rx_tag_reg) & rd_b.mask) == 33'h000000000)
		& ~(bov_reg & |(bufgrp_reg & (ONE_OBJ << rx_obj_reg)));
	assign hw_we = rx_match | EVT.tx_ok;
	assign bus_we = wr & mem_field;

	always_comb begin
		wmask = '0;
		wdata = '0;
		waddr = objsel_reg;
		if (rx_match) begin
			waddr = rx_obj_reg;
			wmask.tag = '1;
			wmask.stamp = '1;
			wdata.tag = rx_tag_reg;
			wdata.stamp = timer_reg;
		end else if (EVT.tx_ok) begin
			waddr = EVT.obj;
			wmask.stamp = '1;
			wdata.stamp = timer_reg;
		end else begin
			wdata.tag = {AVS_WRITEDATA[3:0], AVS_WRITEDATA[28:0]};
			wdata.mask = {AVS_WRITEDATA[3:0], AVS_WRITEDATA[28:0]};
			case (AVS_ADDRESS)
				OFS_TAGID: wmask.tag[28:0] = '1;
				OFS_TAGFL: wmask.tag[32:29] = '1;
				OFS_MSKID: wmask.mask[28:0] = '1;
				OFS_MSKFL: wmask.mask[32:29] = '1;
				default: ;
			endcase
		end
	end

	obj_store #(.W($bits(obj_entry_type)), .D(OBJ_N), .AW(OBJ_AW)) u_store (
		.clk(CLK),
		.we(hw_we | bus_we),
		.waddr(waddr),
		.wmask(wmask),
		.wdata(wdata),
		.raddr_a(objsel_next),
		.rdata_a(rd_a),
		.raddr_b(EVT.obj),
		.rdata_b(rd_b)
	);

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			rx_chk_reg <= 1'b0;
			rx_obj_reg <= '0;
			rx_tag_reg <= '0;
		end else begin
			rx_chk_reg <= EVT.rx_done & (EVT.obj < OBJ_AW'(OBJ_N));
			if (EVT.rx_done) begin
				rx_obj_reg <= EVT.obj;
				rx_tag_reg <= {EVT.ide, EVT.reserved_bits_tag, EVT.remote_request_tag, EVT.identifier_tag};
			end
		end
	end

	// ----------------------------------------
	// Flags and interrupt
	// ----------------------------------------
	assign clr_vec = (wr && AVS_ADDRESS == OFS_OBJSTAT) ? sel_vec : '0;

	// Set wins over a clear in the same cycle
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			rxok_reg <= '0;
			transmit_ok_flag_reg <= '0;
			oerr_reg <= '0;
		end else begin
			rxok_reg <= (rxok_reg & ~(clr_vec & {OBJ_N{AVS_WRITEDATA[OS_RXOK]}}))
				| (rx_match ? ONE_OBJ << rx_obj_reg : '0);
			transmit_ok_flag_reg <= (transmit_ok_flag_reg & ~(clr_vec & {OBJ_N{AVS_WRITEDATA[OS_TRANSMIT_OK_FLAG]}}))
				| (EVT.tx_ok ? ONE_OBJ << EVT.obj : '0);
			oerr_reg <= (oerr_reg & ~(clr_vec & {OBJ_N{AVS_WRITEDATA[OS_ERR]}}))
				| (EVT.err_valid & EVT.err_obj_valid ? ONE_OBJ << EVT.obj : '0);
		end
	end

	assign full_now = (bufgrp_reg != '0) && ((rxok_reg & bufgrp_reg) == bufgrp_reg);
	assign timer_wrap = ena_reg && timer_reg == TIMER_MAX;

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			gen_err_reg <= '0;
			tov_reg <= 1'b0;
			bov_reg <= 1'b0;
			full_d_reg <= 1'b0;
		end else begin
			full_d_reg <= full_now;
			// Bit by bit: a new error keeps its flag even when software clears it in the same cycle
			gen_err_reg <= (gen_err_reg
				& ~((wr && AVS_ADDRESS == OFS_GIRQ) ? AVS_WRITEDATA[4:0] : 5'h00))
				| ((EVT.err_valid & ~EVT.err_obj_valid) ? EVT.err_kind : 5'h00)
				| {4'h0, EVT.err_valid & ~EVT.err_obj_valid & EVT.err_kind[GI_FORM] & EVT.err_in_tx};
			if (timer_wrap) begin
				tov_reg <= 1'b1;
			end else if (wr && AVS_ADDRESS == OFS_GIRQ && AVS_WRITEDATA[GI_TOV]) begin
				tov_reg <= 1'b0;
			end
			if (full_now & ~full_d_reg) begin
				bov_reg <= 1'b1;
			end else if (wr && AVS_ADDRESS == OFS_GIRQ && AVS_WRITEDATA[GI_BOV]) begin
				bov_reg <= 1'b0;
			end
		end
	end

	assign obj_irq_vec = obj_en_reg & ((rxok_reg & {OBJ_N{ie_reg[IE_RX]}}) | (transmit_ok_flag_reg & {OBJ_N{ie_reg[IE_TX]}})
		| (oerr_reg & {OBJ_N{ie_reg[IE_OBJERR]}}));
	assign IRQ = (ie_reg[IE_GLOBAL] & ((|obj_irq_vec) | (ie_reg[IE_GENERR] & |gen_err_reg)
		| (ie_reg[IE_BUF] & bov_reg))) | (ie_reg[IE_TIMER] & tov_reg);

	// ----------------------------------------
	// Timer and trigger capture
	// ----------------------------------------
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			timer_reg <= 16'h0000;
		end else if (!ena_reg) begin
			timer_reg <= 16'h0000;
		end else begin
			timer_reg <= timer_reg + 16'h0001;
		end
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			ttcap_reg <= 16'h0000;
		end else if (tt_reg && (sync_sel_reg ? EVT.eof : EVT.sof)) begin
			ttcap_reg <= timer_reg;
		end
	end

	// ----------------------------------------
	// Fault confinement
	// ----------------------------------------
	logic [9:0] tec_sum;
	assign tec_sum = {1'b0, tec_reg} + TEC_INC;

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			tec_reg <= 9'h000;
			rec_reg <= 8'h00;
		end else if (!ena_reg) begin
			tec_reg <= 9'h000;
			rec_reg <= 8'h00;
		end else if (!listen_reg) begin
			if (EVT.err_valid && EVT.err_in_tx) begin
				tec_reg <= tec_sum > {1'b0, TEC_OFF} ? TEC_OFF : tec_sum[8:0];
			end else if (EVT.tx_ok && tec_reg != 9'h000 && !tec_reg[8]) begin
				tec_reg <= tec_reg - 9'h001;
			end
			if (EVT.err_valid && !EVT.err_in_tx && rec_reg != REC_MAX) begin
				rec_reg <= rec_reg + 8'h01;
			end else if (rx_match && rec_reg != 8'h00) begin
				rec_reg <= rec_reg - 8'h01;
			end
		end
	end

	always_comb begin
		if (tec_reg[8]) begin
			fault = FC_BUSOFF;
		end else if (tec_reg[7] || rec_reg[7]) begin
			fault = FC_PASSIVE;
		end else begin
			fault = FC_ACTIVE;
		end
	end

	// ----------------------------------------
	// Bit timing
	// ----------------------------------------
	logic rx_s1_reg, rx_s2_reg, rx_prev_reg, rx_fall;
	logic [5:0] presc_cnt_reg;
	logic tq_tick, seg_end, resynced_reg;
	seg_type seg_reg;
	logic [3:0] seg_cnt_reg, ext_reg, shrink_reg, sjw_eff;

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			rx_s1_reg <= 1'b1;
			rx_s2_reg <= 1'b1;
			rx_prev_reg <= 1'b1;
		end else begin
			rx_s1_reg <= RX_PIN;
			rx_s2_reg <= rx_s1_reg;
			rx_prev_reg <= rx_s2_reg;
		end
	end

	assign rx_fall = rx_prev_reg & ~rx_s2_reg;
	assign tq_tick = ena_reg && presc_cnt_reg == presc_reg;
	assign sjw_eff = (sjw_reg < ph1_reg) ? {2'b00, sjw_reg} + 4'h1 : {1'b0, ph1_reg} + 4'h1;

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			presc_cnt_reg <= 6'h00;
		end else if (!ena_reg || tq_tick) begin
			presc_cnt_reg <= 6'h00;
		end else begin
			presc_cnt_reg <= presc_cnt_reg + 6'h01;
		end
	end

	always_comb begin
		case (seg_reg)
			SEG_SYNC: seg_end = 1'b1;
			SEG_PROP: seg_end = seg_cnt_reg == {1'b0, prop_reg};
			SEG_PH1: seg_end = seg_cnt_reg == {1'b0, ph1_reg} + ext_reg;
			SEG_PH2: seg_end = seg_cnt_reg + shrink_reg >= {1'b0, ph2_reg};
			default: seg_end = 1'b1;
		endcase
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			seg_reg <= SEG_SYNC;
			seg_cnt_reg <= 4'h0;
		end else if (!ena_reg) begin
			seg_reg <= SEG_SYNC;
			seg_cnt_reg <= 4'h0;
		end else if (tq_tick) begin
			seg_cnt_reg <= seg_end ? 4'h0 : seg_cnt_reg + 4'h1;
			if (seg_end) begin
				case (seg_reg)
					SEG_SYNC: seg_reg <= SEG_PROP;
					SEG_PROP: seg_reg <= SEG_PH1;
					SEG_PH1: seg_reg <= SEG_PH2;
					SEG_PH2: seg_reg <= SEG_SYNC;
					default: seg_reg <= SEG_SYNC;
				endcase
			end
		end
	end

	// One resynchronisation per bit: late edge stretches phase one, early edge cuts phase two
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			ext_reg <= 4'h0;
			shrink_reg <= 4'h0;
			resynced_reg <= 1'b0;
		end else if (seg_reg == SEG_SYNC) begin
			ext_reg <= 4'h0;
			shrink_reg <= 4'h0;
			resynced_reg <= 1'b0;
		end else if (rx_fall && !resynced_reg) begin
			resynced_reg <= 1'b1;
			if (seg_reg == SEG_PH2) begin
				shrink_reg <= sjw_eff;
			end else begin
				ext_reg <= sjw_eff;
			end
		end
	end

	// ----------------------------------------
	// Node control outputs
	// ----------------------------------------
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			susp_reg <= 4'h0;
		end else if ((EVT.tx_ok || (EVT.err_valid && EVT.err_in_tx)) && fault == FC_PASSIVE) begin
			susp_reg <= SUSPEND_BITS;
		end else if (tq_tick && seg_reg == SEG_PH2 && seg_end && susp_reg != 4'h0) begin
			susp_reg <= susp_reg - 4'h1;
		end
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			CTRL <= '0;
		end else begin
			CTRL.drive_allowed <= ena_reg & ~listen_reg & (fault != FC_BUSOFF);
			CTRL.ack_allowed <= ena_reg & ~listen_reg & (fault != FC_BUSOFF);
			CTRL.tx_allowed <= ena_reg & ~listen_reg & (fault != FC_BUSOFF) & (susp_reg == 4'h0);
			CTRL.active_error_frame <= ena_reg & ~listen_reg & (fault == FC_ACTIVE);
			CTRL.retransmit_allowed <= ~tt_reg;
			CTRL.sample_point <= tq_tick & (seg_reg == SEG_PH1) & seg_end;
			CTRL.bit_start <= tq_tick & (seg_reg == SEG_PH2) & seg_end;
			if (tq_tick && seg_reg == SEG_PH1 && seg_end) begin
				CTRL.rx_bit <= rx_s2_reg;
			end
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	logic [6:0] sync_clk_reg;
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			sync_clk_reg <= 7'h00;
		end else if (!ena_reg || seg_reg != SEG_SYNC) begin
			sync_clk_reg <= 7'h00;
		end else begin
			sync_clk_reg <= sync_clk_reg + 7'h01;
		end
	end

	chk_sync_len: assert property (@(posedge CLK) disable iff (!RSTN)
		(seg_reg == SEG_SYNC && ena_reg && $stable(presc_reg) && tq_tick) |-> sync_clk_reg == {1'b0, presc_reg})
		else $error("sync segment length wrong");
	chk_timer_wrap: assert property (@(posedge CLK) disable iff (!RSTN)
		(ena_reg && timer_reg == TIMER_MAX) ##1 ena_reg |-> timer_reg == 16'h0000 && tov_reg)
		else $error("timer did not wrap with overrun");
	chk_timer_irq: assert property (@(posedge CLK) disable iff (!RSTN)
		(tov_reg && ie_reg[IE_TIMER]) |-> IRQ)
		else $error("timer overrun irq missing");
	chk_irq_global: assert property (@(posedge CLK) disable iff (!RSTN)
		(IRQ && !(ie_reg[IE_TIMER] && tov_reg)) |-> ie_reg[IE_GLOBAL])
		else $error("irq without global enable");
	chk_form_bit: assert property (@(posedge CLK) disable iff (!RSTN)
		(EVT.err_valid && !EVT.err_obj_valid && EVT.err_kind[GI_FORM] && EVT.err_in_tx) |=> gen_err_reg[GI_BIT])
		else $error("form error while sending lacks bit error");
	chk_obj_no_gen: assert property (@(posedge CLK) disable iff (!RSTN)
		(EVT.err_valid && EVT.err_obj_valid) |=> (gen_err_reg & ~$past(gen_err_reg)) == 5'h00)
		else $error("object error set a general flag");
	chk_listen_frozen: assert property (@(posedge CLK) disable iff (!RSTN)
		(listen_reg && ena_reg) ##1 ena_reg |-> $stable(tec_reg) && $stable(rec_reg))
		else $error("error counters moved in listen mode");
	chk_tt_capture: assert property (@(posedge CLK) disable iff (!RSTN)
		(tt_reg && !sync_sel_reg && EVT.sof) |=> ttcap_reg == $past(timer_reg))
		else $error("trigger capture missed");
	chk_busoff_quiet: assert property (@(posedge CLK) disable iff (!RSTN)
		tec_reg[8] |=> !CTRL.drive_allowed && !CTRL.tx_allowed)
		else $error("bus-off node may drive");
	chk_tx_stamp: assert property (@(posedge CLK) disable iff (!RSTN)
		(EVT.tx_ok && !rx_match) |-> hw_we && wmask.stamp == 16'hFFFF && wdata.stamp == timer_reg)
		else $error("transmit stamp not written");
endmodule : can_ctl

/* File: bench/can_node_model.sv */
`timescale 1ns/1ps
module can_node_model (
	input wire logic clk,
	input wire logic rstn,
	input wire logic dominant,
	output logic rx_pin
);
	// ----
	// Bus level, recessive when idle
	// ----
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rx_pin <= 1'b1;
		end else begin
			rx_pin <= ~dominant;
		end
	end
endmodule : can_node_model

/* File: bench/can_irq_bittiming_timestamp_tb_top.sv */
`timescale 1ns/1ps
module can_irq_bittiming_timestamp_tb_top;
	import can_ctl_pkg::*;
	logic clk, rstn, rd, wr, wreq, irq, dom, rxp;
	logic [7:0] adr;
	logic [31:0] wd, rdat, d, t0;
	logic [15:0] lf;
	logic [3:0] o;
	frame_event_type evt, fe;
	node_ctrl_type ctrl;
	int n_errors, comparisons, per, t;
	can_ctl dut (.CLK(clk), .RSTN(rstn), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
		.AVS_WRITEDATA(wd), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq), .RX_PIN(rxp),
		.EVT(evt), .CTRL(ctrl), .IRQ(irq));
	can_node_model peer (.clk(clk), .rstn(rstn), .dominant(dom), .rx_pin(rxp));
	// ----
	// Helpers
	// ----
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("FAIL %s exp %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		adr <= a;
		wd <= v;
		rd <= !w;
		wr <= w;
		do @(posedge clk); while (wreq !== 1'b0);
		d = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
		@(negedge clk);
	endtask : bus
	task automatic pulse(input frame_event_type e);
		@(posedge clk);
		evt <= e;
		@(posedge clk);
		evt <= '0;
		repeat (3) @(posedge clk);
	endtask : pulse
	task automatic report_and_stop;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		repeat (90000) @(posedge clk);
		n_errors++;
		report_and_stop();
	end
	// ----
	// Scenarios
	// ----
	initial begin
		{rstn, rd, wr, dom, adr, wd} = '0;
		evt = '0;
		lf = 16'h0035;
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		bus(0, OFS_IRQEN, 0);
		check("irqen reset", d, 0);
		bus(0, 8'h02, 0);
		check("unmapped", d, 0);
		for (int k = 0; k < 3; k++) begin
			lf = lfsr(lf);
			bus(1, OFS_GCTRL, 0);
			bus(1, OFS_BTIME, {10'h0, lf[9:8], 1'b0, 3'h1, 1'b0, lf[7:5] | 3'h1, 1'b0, lf[4:2] | 3'h2, 6'h0, lf[1:0]});
			bus(1, OFS_GCTRL, 32'h2);
			per = (lf[1:0] + 1) * ((lf[4:2] | 3'h2) + (lf[7:5] | 3'h1) + 5);
			do @(negedge clk); while (ctrl.bit_start !== 1'b1);
			t = 0;
			do begin @(negedge clk); t++; end while (ctrl.bit_start !== 1'b1);
			check("bit period", t, per);
		end
		@(posedge clk);
		dom <= 1'b1;
		repeat (3) do @(negedge clk); while (ctrl.bit_start !== 1'b1);
		check("rx bit", ctrl.rx_bit, 0);
		dom <= 1'b0;
		bus(0, OFS_TIMER, 0);
		t0 = d;
		bus(0, OFS_TIMER, 0);
		check("timer step", d - t0, 3);
		o = lf[3:0] % 4'hF;
		bus(1, OFS_IRQEN, 32'h41);
		bus(1, OFS_OBJEN, 1 << o);
		bus(1, OFS_OBJSEL, {28'h0, o});
		bus(0, OFS_TIMER, 0);
		t0 = d;
		fe = '0;
		fe.tx_ok = 1'b1;
		fe.obj = o;
		pulse(fe);
		check("tx irq", irq, 1);
		bus(0, OFS_STAMP, 0);
		check("stamp", d[15:0], t0[15:0] + 3);
		bus(0, OFS_OBJIRQ, 0);
		check("obj irq status", d, 1 << o);
		bus(1, OFS_OBJSTAT, 32'h2);
		check("tx ack", irq, 0);
		bus(1, OFS_IRQEN, 32'h10);
		fe = '0;
		fe.err_valid = 1'b1;
		fe.err_kind = 5'h01;
		fe.err_obj_valid = 1'b1;
		fe.obj = o;
		pulse(fe);
		check("obj err no global", irq, 0);
		bus(1, OFS_IRQEN, 32'h11);
		check("obj err irq", irq, 1);
		bus(0, OFS_GIRQ, 0);
		check("no general err", d[4:0], 0);
		bus(1, OFS_OBJSTAT, 32'h4);
		fe = '0;
		fe.err_valid = 1'b1;
		fe.err_kind = 5'h08;
		fe.err_in_tx = 1'b1;
		pulse(fe);
		bus(0, OFS_GIRQ, 0);
		check("form plus bit", d[4:0], 5'h09);
		bus(1, OFS_IRQEN, 32'h13);
		check("general irq", irq, 1);
		bus(1, OFS_GIRQ, 32'h1F);
		bus(1, OFS_GCTRL, 32'h0A);
		fe = '0;
		fe.err_valid = 1'b1;
		fe.err_kind = 5'h02;
		pulse(fe);
		check("listen ack", ctrl.ack_allowed, 0);
		check("listen tx", ctrl.tx_allowed, 0);
		bus(0, OFS_ERRCNT, 0);
		check("counters frozen", d, 32'h00010008);
		bus(0, OFS_GIRQ, 0);
		check("listen flags", d[4:0], 5'h02);
		bus(1, OFS_GIRQ, 32'h1F);
		bus(1, OFS_GCTRL, 32'h22);
		bus(0, OFS_TIMER, 0);
		t0 = d;
		fe = '0;
		fe.sof = 1'b1;
		pulse(fe);
		bus(0, OFS_TTCAP, 0);
		check("sof capture", d[15:0], t0[15:0] + 16'h3);
		check("single shot", ctrl.retransmit_allowed, 0);
		bus(1, OFS_GCTRL, 32'h02);
		bus(1, OFS_MSKID, 0);
		bus(1, OFS_MSKFL, 0);
		bus(1, OFS_BUFGRP, 1 << o);
		bus(1, OFS_IRQEN, 32'h05);
		lf = lfsr(lf);
		bus(0, OFS_TIMER, 0);
		t0 = d;
		fe = '0;
		fe.rx_done = 1'b1;
		fe.obj = o;
		fe.identifier_tag = {lf, 13'h1A5};
		fe.remote_request_tag = 1'b1;
		fe.ide = 1'b1;
		pulse(fe);
		check("buffer irq", irq, 1);
		bus(0, OFS_STAMP, 0);
		check("rx stamp", d[15:0], t0[15:0] + 16'h4);
		bus(0, OFS_TAGID, 0);
		check("tag id", d, {3'h0, lf, 13'h1A5});
		bus(0, OFS_TAGFL, 0);
		check("tag flags", d, 32'h9);
		bus(0, OFS_GIRQ, 0);
		check("buffer full", d[6:0], 7'h40);
		bus(1, OFS_GIRQ, 32'h40);
		check("buffer ack", irq, 0);
		bus(1, OFS_IRQEN, 32'h20);
		bus(0, OFS_OBJIRQ, 0);
		check("rx obj status", d, 1 << o);
		bus(0, OFS_ERRCNT, 0);
		check("rec after ok", d, 32'h00000008);
		check("active node", {ctrl.drive_allowed, ctrl.active_error_frame}, 2'b11);
		bus(1, OFS_OBJSTAT, 32'h1);
		bus(1, OFS_IRQEN, 32'h8);
		t = 0;
		while (irq !== 1'b1 && t < 70000) begin @(negedge clk); t++; end
		check("rollover irq", irq, 1);
		bus(0, OFS_GIRQ, 0);
		check("overrun flag", d[GI_TOV], 1);
		bus(1, OFS_GIRQ, 32'h20);
		check("overrun ack", irq, 0);
		report_and_stop();
	end
endmodule : can_irq_bittiming_timestamp_tb_top
